// [hw/uiw_pkg.sv]
/*
 * Constants shared by the UART interrupt and wake-up block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package uiw_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;

    localparam logic [7:0] CTRL_OFFS   = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    localparam logic [7:0] DATA_OFFS   = 8'h08;

    localparam int unsigned TX_EMPTY_IE_BIT  = 0;
    localparam int unsigned TX_IDLE_IE_BIT   = 1;
    localparam int unsigned RX_IE_BIT        = 2;
    localparam int unsigned ADDR_DET_BIT     = 3;
    localparam int unsigned PIN_WAKE_BIT     = 4;
    localparam int unsigned NINE_BIT_BIT     = 5;
    localparam int unsigned PARITY_BIT       = 6;
    localparam int unsigned UART_EN_BIT      = 7;
    localparam int unsigned RX_EN_BIT        = 8;
    localparam int unsigned CTRL_WIDTH       = 9;
    localparam logic [8:0]  CTRL_RESET       = 9'h000;

    localparam int unsigned ST_TX_EMPTY_BIT  = 0;
    localparam int unsigned ST_TX_IDLE_BIT   = 1;
    localparam int unsigned ST_RX_AVAIL_BIT  = 2;
    localparam int unsigned ST_OVERRUN_BIT   = 3;
    localparam int unsigned ST_RX_TRIG_BIT   = 4;
    localparam int unsigned ST_WAKE_BIT      = 5;
    localparam int unsigned ST_IRQ_BIT       = 6;

    localparam int unsigned WAKE_RECOVERY_NS = 1000;
    localparam int unsigned WAKE_RECOVERY_CYC =
        (WAKE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  RECOVERY_LOAD = 8'(WAKE_RECOVERY_CYC);

    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

    typedef enum logic [1:0] {
        WK_RUN,
        WK_ASLEEP,
        WK_RECOVER
    } uiw_wake_t;
endpackage
`default_nettype wire

// [hw/uiw_uart_irq.sv]
/*
 * UART interrupt request and receive-pin wake-up logic with an AHB-Lite
 * register slave (control, status, receive data).
 * Assumes the UART core reports its conditions as synchronous levels and
 * pulses on clk, and that clk keeps running while the UART clock is off.
 */
// Functional notes
// - Six conditions can request the UART interrupt.
// - Any enabled condition gives active-low pulse; here only if no other was already active.
// - Enables gate flags; receive conditions share one.
// - Address word with detect enabled interrupts.
// - Pin falling edge wakes when clock off.
// - Wake also needs unit and receiver enables.
// - Flags read-only, cleared only by UART actions.
// - Address mode: interrupt only if top bit set.
// - Top bit is ninth or eighth per width.
// - Without address mode, every receive flag interrupts.
// - Transmission freezes while clock off, then resumes.
// - Reception pauses, not aborts, in idle/sleep.
// - Registers keep contents across idle/sleep.
// - Received data discarded during wake recovery.
// - Without global/UART enable, wake gives no interrupt.
// - Wake interrupt waits for recovery to elapse.
// - Overrun interrupts when receive interrupt enable set.
// - Overrun clears after status read then data read.
`timescale 1ns/1ps
`default_nettype none
module uiw_uart_irq (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        txEmpty,
    input  wire logic        txIdle,
    input  wire logic        rxFifoTrig,
    input  wire logic        rxWordPush,
    input  wire logic [8:0]  rxWord,
    input  wire logic        rxOverrunEvt,
    input  wire logic        uartClkOff,
    input  wire logic        serialRxPin,
    input  wire logic        globalIrqEnable,
    input  wire logic        uartIrqEnable,
    output var  logic        uartIrqPulse_n,
    output var  logic        wakeRequest,
    output var  logic        txFreeze,
    output var  logic        rxFreeze,
    output var  logic        rxDiscard,
    output var  logic        rxDataPop,
    output var  logic        nineBitSelect,
    output var  logic        parityEnable
);
    // Control and status state.
    logic [8:0]  ctrl_reg, ctrl_next;
    logic        rxAvail_reg, rxAvail_next;
    logic        overrun_reg, overrun_next;
    logic        statusSeen_reg, statusSeen_next;
    logic        addrMsb_reg, addrMsb_next;
    logic        addrEvt_reg, addrEvt_next;
    logic        wakeIrq_reg, wakeIrq_next;
    logic        irqLevel_reg, irqLevel_next;
    logic        pulse_n_reg, pulse_n_next;
    logic        pinPrev_reg, pinPrev_next;
    logic        wakeReq_reg, wakeReq_next;
    logic        freeze_reg, freeze_next;
    logic        discard_reg, discard_next;
    logic [7:0]  recCnt_reg, recCnt_next;
    uiw_pkg::uiw_wake_t wake_reg, wake_next;

    // Bus state.
    logic        dpWrite_reg, dpWrite_next;
    logic [7:0]  dpAddr_reg, dpAddr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        pop_reg, pop_next;

    logic        addrPhase;
    logic        statusRead;
    logic        dataRead;
    logic        wordMsb;
    logic        rxIe;
    logic        irqAny;
    logic [6:0]  statusWord;

    function automatic logic pick_msb(input logic [8:0] word, input logic nine);
        pick_msb = nine ? word[8] : word[7];
    endfunction

    always_comb begin
        // A transfer is taken only in a NONSEQ address phase with the bus ready.
        addrPhase  = hsel && hready && (htrans == uiw_pkg::HTRANS_NONSEQ);
        statusRead = addrPhase && !hwrite && (haddr[7:0] == uiw_pkg::STATUS_OFFS);
        dataRead   = addrPhase && !hwrite && (haddr[7:0] == uiw_pkg::DATA_OFFS);
        wordMsb    = pick_msb(rxWord, ctrl_reg[uiw_pkg::NINE_BIT_BIT]);
        rxIe       = ctrl_reg[uiw_pkg::RX_IE_BIT];

        // Enabled conditions are OR-ed into one request level.
        irqAny = (ctrl_reg[uiw_pkg::TX_EMPTY_IE_BIT] && txEmpty)
            || (ctrl_reg[uiw_pkg::TX_IDLE_IE_BIT] && txIdle)
            || (rxIe && rxFifoTrig && rxAvail_reg
                && (!ctrl_reg[uiw_pkg::ADDR_DET_BIT] || addrMsb_reg))
            || (rxIe && overrun_reg)
            || addrEvt_reg
            || wakeIrq_reg;

        // Status bits are placed by their named positions.
        statusWord = 7'h00;
        statusWord[uiw_pkg::ST_TX_EMPTY_BIT] = txEmpty;
        statusWord[uiw_pkg::ST_TX_IDLE_BIT]  = txIdle;
        statusWord[uiw_pkg::ST_RX_AVAIL_BIT] = rxAvail_reg;
        statusWord[uiw_pkg::ST_OVERRUN_BIT]  = overrun_reg;
        statusWord[uiw_pkg::ST_RX_TRIG_BIT]  = rxFifoTrig;
        statusWord[uiw_pkg::ST_WAKE_BIT]     = (wake_reg != uiw_pkg::WK_RUN);
        statusWord[uiw_pkg::ST_IRQ_BIT]      = irqLevel_reg;
    end

    always_comb begin
        ctrl_next       = ctrl_reg;
        rxAvail_next    = rxAvail_reg;
        overrun_next    = overrun_reg;
        statusSeen_next = statusSeen_reg;
        addrMsb_next    = addrMsb_reg;
        addrEvt_next    = 1'b0;
        wakeIrq_next    = 1'b0;
        wakeReq_next    = 1'b0;
        pinPrev_next    = serialRxPin;
        freeze_next     = uartClkOff;
        recCnt_next     = recCnt_reg;
        wake_next       = wake_reg;
        dpWrite_next    = 1'b0;
        dpAddr_next     = dpAddr_reg;
        rdata_next      = rdata_reg;
        pop_next        = 1'b0;

        // Bus: address phase captures, data phase writes control.
        // Read data is picked in the address phase, so that in the data phase
        // hrdata comes straight from a flip-flop with no wait state.
        if (addrPhase) begin
            dpWrite_next = hwrite;
            dpAddr_next  = haddr[7:0];
            rdata_next   = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    uiw_pkg::CTRL_OFFS:   rdata_next = {23'h00_0000, ctrl_reg};
                    uiw_pkg::STATUS_OFFS: rdata_next = {25'h000_0000, statusWord};
                    uiw_pkg::DATA_OFFS:   rdata_next = {23'h00_0000, rxWord};
                    default:              rdata_next = 32'h0000_0000;
                endcase
            end
            pop_next = dataRead;
        end
        if (dpWrite_reg && dpAddr_reg == uiw_pkg::CTRL_OFFS) begin
            ctrl_next = hwdata[8:0];
        end

        // Flags clear only by a status read followed by a data read.
        if (statusRead) begin
            statusSeen_next = 1'b1;
        end
        if (dataRead && statusSeen_reg) begin
            rxAvail_next    = 1'b0;
            overrun_next    = 1'b0;
            statusSeen_next = 1'b0;
        end

        // Receive events; set wins over a simultaneous clear.
        // Words arriving during wake recovery are dropped.
        if (rxWordPush && !discard_reg) begin
            rxAvail_next = 1'b1;
            addrMsb_next = wordMsb;
            addrEvt_next = ctrl_reg[uiw_pkg::ADDR_DET_BIT] && wordMsb;
        end
        if (rxOverrunEvt && !discard_reg) begin
            overrun_next = 1'b1;
        end

        // Pin wake-up while the UART clock is stopped.
        unique case (wake_reg)
            uiw_pkg::WK_RUN: begin
                if (uartClkOff && ctrl_reg[uiw_pkg::PIN_WAKE_BIT]
                    && ctrl_reg[uiw_pkg::RX_IE_BIT]
                    && ctrl_reg[uiw_pkg::UART_EN_BIT]
                    && ctrl_reg[uiw_pkg::RX_EN_BIT]) begin
                    wake_next = uiw_pkg::WK_ASLEEP;
                end
            end
            uiw_pkg::WK_ASLEEP: begin
                // A pin fall in the cycle the clock returns still wakes; no edge is lost.
                if (pinPrev_reg && !serialRxPin) begin
                    wakeReq_next = 1'b1;
                    wake_next    = uiw_pkg::WK_RECOVER;
                    recCnt_next  = uiw_pkg::RECOVERY_LOAD;
                end else if (!uartClkOff) begin
                    wake_next = uiw_pkg::WK_RUN;
                end
            end
            uiw_pkg::WK_RECOVER: begin
                // Count only once the clock is back; hold the interrupt until done.
                if (!uartClkOff) begin
                    recCnt_next = recCnt_reg - 8'h01;
                    if (recCnt_reg == 8'h01) begin
                        wake_next    = uiw_pkg::WK_RUN;
                        wakeIrq_next = globalIrqEnable && uartIrqEnable;
                    end
                end
            end
            // The spare state code falls back to running.
            default: wake_next = uiw_pkg::WK_RUN;
        endcase
        // Discard follows the next state, so it already covers the cycle after the wake edge.
        discard_next = (wake_next == uiw_pkg::WK_RECOVER);

        // A request rising edge drives one low cycle on the interrupt line.
        // A request that stays high gives no second pulse: every enabled condition
        // must fall before a new one can be seen by the interrupt controller.
        irqLevel_next = irqAny;
        pulse_n_next  = !(irqAny && !irqLevel_reg);
    end

    // Sleep does not touch these registers: only rst resets them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg       <= uiw_pkg::CTRL_RESET;
            rxAvail_reg    <= 1'b0;
            overrun_reg    <= 1'b0;
            statusSeen_reg <= 1'b0;
            addrMsb_reg    <= 1'b0;
            addrEvt_reg    <= 1'b0;
            wakeIrq_reg    <= 1'b0;
            irqLevel_reg   <= 1'b0;
            pulse_n_reg    <= 1'b1;
            // The pin sample resets to the idle mark level, so that leaving
            // reset is never taken for a falling edge.
            pinPrev_reg    <= 1'b1;
            wakeReq_reg    <= 1'b0;
            freeze_reg     <= 1'b0;
            discard_reg    <= 1'b0;
            recCnt_reg     <= 8'h00;
            wake_reg       <= uiw_pkg::WK_RUN;
            dpWrite_reg    <= 1'b0;
            dpAddr_reg     <= 8'h00;
            rdata_reg      <= 32'h0000_0000;
            pop_reg        <= 1'b0;
        end else begin
            ctrl_reg       <= ctrl_next;
            rxAvail_reg    <= rxAvail_next;
            overrun_reg    <= overrun_next;
            statusSeen_reg <= statusSeen_next;
            addrMsb_reg    <= addrMsb_next;
            addrEvt_reg    <= addrEvt_next;
            wakeIrq_reg    <= wakeIrq_next;
            irqLevel_reg   <= irqLevel_next;
            pulse_n_reg    <= pulse_n_next;
            pinPrev_reg    <= pinPrev_next;
            wakeReq_reg    <= wakeReq_next;
            freeze_reg     <= freeze_next;
            discard_reg    <= discard_next;
            recCnt_reg     <= recCnt_next;
            wake_reg       <= wake_next;
            dpWrite_reg    <= dpWrite_next;
            dpAddr_reg     <= dpAddr_next;
            rdata_reg      <= rdata_next;
            pop_reg        <= pop_next;
        end
    end

    // Outputs from flip-flops; the slave never stalls and always says OKAY.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        hrdata         = rdata_reg;
        uartIrqPulse_n = pulse_n_reg;
        wakeRequest    = wakeReq_reg;
        txFreeze       = freeze_reg;
        rxFreeze       = freeze_reg;
        rxDiscard      = discard_reg;
        rxDataPop      = pop_reg;
        nineBitSelect  = ctrl_reg[uiw_pkg::NINE_BIT_BIT];
        // Parity and address detection are not interlocked here; software must
        // keep them apart.
        parityEnable   = ctrl_reg[uiw_pkg::PARITY_BIT];
    end
endmodule
`default_nettype wire

// [tb/uiw_uart_irq_props.sv]
/* Port checker for uiw_uart_irq.
   Assumes hready is tied to hreadyout; bound to every design instance. */
`timescale 1ns/1ps
`default_nettype none
module uiw_uart_irq_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        uartClkOff,
    input wire logic        serialRxPin,
    input wire logic        uartIrqPulse_n,
    input wire logic        wakeRequest,
    input wire logic        txFreeze,
    input wire logic        rxFreeze,
    input wire logic        rxDiscard,
    input wire logic        rxDataPop
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic dataRd;
    assign dataRd = hsel && hreadyout && !hwrite && htrans == uiw_pkg::HTRANS_NONSEQ
        && haddr[7:0] == uiw_pkg::DATA_OFFS;
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not OKAY");
    chk_pulse_one: assert property (!uartIrqPulse_n |=> uartIrqPulse_n)
        else $error("interrupt pulse longer than one cycle");
    chk_pop_read: assert property (dataRd |=> rxDataPop)
        else $error("data read gave no pop");
    chk_pop_cause: assert property (rxDataPop |-> $past(dataRd))
        else $error("pop without data read");
    chk_freeze_on: assert property ($rose(uartClkOff) |=> txFreeze && rxFreeze)
        else $error("transfers not frozen");
    chk_freeze_off: assert property ($fell(uartClkOff) |=> !txFreeze && !rxFreeze)
        else $error("transfers not resumed");
    chk_wake_cause: assert property ($rose(wakeRequest) |->
        !$past(serialRxPin) && $past(uartClkOff, 2)) else $error("wake without pin fall");
    chk_wake_single: assert property (wakeRequest |=> !wakeRequest)
        else $error("wake pulse too long");
    chk_wake_discard: assert property ($rose(wakeRequest) |-> ##[0:2] rxDiscard)
        else $error("no discard after wake");
    chk_recovery_len: assert property ($fell(uartClkOff) && rxDiscard |->
        rxDiscard [*8] ##[10:25] !rxDiscard) else $error("recovery length wrong");
endmodule
bind uiw_uart_irq uiw_uart_irq_props chk_u (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
    .hresp(hresp), .uartClkOff(uartClkOff), .serialRxPin(serialRxPin),
    .uartIrqPulse_n(uartIrqPulse_n), .wakeRequest(wakeRequest), .txFreeze(txFreeze),
    .rxFreeze(rxFreeze), .rxDiscard(rxDiscard), .rxDataPop(rxDataPop));
`default_nettype wire

// [tb/uiw_far_end.sv]
/* Far-end model: remote transmitter driving the receive pin and the
   interrupt controller that services pulses. Assumes one shared clock. */
`timescale 1ns/1ps
`default_nettype none
module uiw_far_end #(
    parameter bit STACK_FULL = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       fallReq,
    input  wire logic       irqPulse_n,
    input  wire logic       globalIrqEnable,
    input  wire logic       multifuncIrqEnable,
    input  wire logic       uartIrqEnable,
    output var  logic       serialRxPin,
    output var  logic [7:0] servedCount
);
    logic [3:0] lowCnt;
    // The line idles at mark level; a start bit holds it low for twelve cycles.
    assign serialRxPin = (lowCnt == 4'h0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowCnt      <= 4'h0;
            servedCount <= 8'h00;
        end else begin
            lowCnt <= fallReq ? 4'hc : lowCnt - {3'h0, lowCnt != 4'h0};
            if (!irqPulse_n && globalIrqEnable && multifuncIrqEnable
                && uartIrqEnable && !STACK_FULL) begin
                servedCount <= servedCount + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/test_uart_interrupt_and_wakeup.sv]
/* Self-checking bench for uiw_uart_irq with the far-end model.
   Assumes the checker binds itself and a 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_uart_interrupt_and_wakeup;
    typedef struct packed {
        logic [8:0] ctrl;
        logic       txE, txI, trig, push;
        logic [8:0] word;
        logic       ovr, exp;
    } uiw_row_t;
    // Fields: control, {txEmpty txIdle trig push}, word, {overrun expected}.
    localparam uiw_row_t ROWS [11] = '{
        {9'h001, 4'h8, 9'h000, 2'h1}, {9'h002, 4'h8, 9'h000, 2'h0},
        {9'h002, 4'h4, 9'h000, 2'h1}, {9'h001, 4'h4, 9'h000, 2'h0},
        {9'h004, 4'h0, 9'h000, 2'h3}, {9'h000, 4'h0, 9'h000, 2'h2},
        {9'h004, 4'h3, 9'h000, 2'h1}, {9'h00c, 4'h3, 9'h000, 2'h0},
        {9'h00c, 4'h3, 9'h080, 2'h1}, {9'h02c, 4'h3, 9'h080, 2'h0},
        {9'h028, 4'h1, 9'h100, 2'h1}};
    logic        clk, rst, hsel, hwrite, txEmpty, txIdle, rxFifoTrig, rxWordPush;
    logic        rxOverrunEvt, uartClkOff, globalIrqEnable, uartIrqEnable, fallReq;
    logic        mfEnable, hreadyout, hresp, uartIrqPulse_n, wakeRequest, txFreeze;
    logic        rxFreeze, rxDiscard, rxDataPop, nineBitSelect, parityEnable, serialRxPin;
    logic        got;
    logic [1:0]  htrans;
    logic [8:0]  rxWord;
    logic [7:0]  servedCount;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          failures, compares;
    uiw_uart_irq dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txEmpty(txEmpty), .txIdle(txIdle), .rxFifoTrig(rxFifoTrig),
        .rxWordPush(rxWordPush), .rxWord(rxWord), .rxOverrunEvt(rxOverrunEvt),
        .uartClkOff(uartClkOff), .serialRxPin(serialRxPin),
        .globalIrqEnable(globalIrqEnable), .uartIrqEnable(uartIrqEnable),
        .uartIrqPulse_n(uartIrqPulse_n), .wakeRequest(wakeRequest), .txFreeze(txFreeze),
        .rxFreeze(rxFreeze), .rxDiscard(rxDiscard), .rxDataPop(rxDataPop),
        .nineBitSelect(nineBitSelect), .parityEnable(parityEnable));
    uiw_far_end far_u (.clk(clk), .rst(rst), .fallReq(fallReq), .irqPulse_n(uartIrqPulse_n),
        .globalIrqEnable(globalIrqEnable), .multifuncIrqEnable(mfEnable),
        .uartIrqEnable(uartIrqEnable), .serialRxPin(serialRxPin), .servedCount(servedCount));
    task automatic end_of_test();
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= uiw_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask
    task automatic watch(input int n, input logic wk, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if ((wk ? wakeRequest : !uartIrqPulse_n) === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic wakeTry(input logic [31:0] ctrl, input logic expWake);
        bus(1'b1, uiw_pkg::CTRL_OFFS, ctrl);
        uartClkOff <= 1'b1;
        repeat (3) @(posedge clk);
        check("freeze", {txFreeze, rxFreeze}, 2'h3);
        fallReq <= 1'b1;
        @(posedge clk);
        fallReq <= 1'b0;
        watch(6, 1'b1, got);
        check("wake", got, expWake);
        rxWordPush <= 1'b1;
        rxOverrunEvt <= 1'b1;
        @(posedge clk);
        rxWordPush <= 1'b0;
        rxOverrunEvt <= 1'b0;
        uartClkOff <= 1'b0;
        watch(15, 1'b0, got);
        check("early irq", got, !expWake);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {hsel, hwrite, txEmpty, txIdle, rxFifoTrig, rxWordPush, rxOverrunEvt} = 7'h00;
        {uartClkOff, fallReq, mfEnable} = 3'h0;
        {globalIrqEnable, uartIrqEnable, rst} = 3'h7;
        {htrans, rxWord, haddr, hwdata, failures, compares} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            {txEmpty, txIdle, rxFifoTrig} <= 3'h0;
            bus(1'b1, uiw_pkg::CTRL_OFFS, 32'h0000_0000);
            bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
            bus(1'b0, uiw_pkg::DATA_OFFS, 32'h0000_0000);
            bus(1'b1, uiw_pkg::CTRL_OFFS, {23'h00_0000, ROWS[i].ctrl});
            {txEmpty, txIdle, rxFifoTrig, rxWordPush} <= {ROWS[i].txE, ROWS[i].txI,
                ROWS[i].trig, ROWS[i].push};
            rxWord <= ROWS[i].word;
            rxOverrunEvt <= ROWS[i].ovr;
            @(posedge clk);
            {rxWordPush, rxOverrunEvt} <= 2'h0;
            watch(6, 1'b0, got);
            check("irq row", got, ROWS[i].exp);
        end
        rxOverrunEvt <= 1'b1;
        @(posedge clk);
        rxOverrunEvt <= 1'b0;
        bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        check("overrun set", rd[3], 1'b1);
        bus(1'b1, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        check("status ro", rd[3], 1'b1);
        bus(1'b0, uiw_pkg::DATA_OFFS, 32'h0000_0000);
        bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        check("overrun clr", rd[3:2], 2'h0);
        bus(1'b1, uiw_pkg::CTRL_OFFS, 32'h0000_0060);
        @(posedge clk);
        check("ctrl bits", {nineBitSelect, parityEnable}, 2'h3);
        bus(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        mfEnable <= 1'b1;
        wakeTry(32'h0000_0194, 1'b1);
        watch(30, 1'b0, got);
        check("wake irq", got, 1'b1);
        bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        check("discarded", rd[3:2], 2'h0);
        bus(1'b0, uiw_pkg::CTRL_OFFS, 32'h0000_0000);
        check("ctrl kept", rd, 32'h0000_0194);
        check("served", servedCount, 8'h01);
        wakeTry(32'h0000_0114, 1'b0);
        bus(1'b0, uiw_pkg::STATUS_OFFS, 32'h0000_0000);
        check("kept rx", rd[3:2], 2'h3);
        bus(1'b0, uiw_pkg::DATA_OFFS, 32'h0000_0000);
        globalIrqEnable <= 1'b0;
        wakeTry(32'h0000_0194, 1'b1);
        watch(30, 1'b0, got);
        check("gated wake", got, 1'b0);
        rst <= 1'b1;
        @(posedge clk);
        check("reset outs", {uartIrqPulse_n, wakeRequest, rxDiscard, hreadyout}, 4'h9);
        rst <= 1'b0;
        bus(1'b0, uiw_pkg::CTRL_OFFS, 32'h0000_0000);
        check("ctrl reset", rd, {23'h00_0000, uiw_pkg::CTRL_RESET});
        end_of_test();
    end
endmodule
`default_nettype wire
